// ### rtl/sidd_defines.svh
// Register map, field positions and timing constants of the sound IF path
`ifndef SIDD_DEFINES_SVH
`define SIDD_DEFINES_SVH
`define SIDD_ADDR_MISC     12'h102
`define SIDD_ADDR_FE1      12'h104
`define SIDD_ADDR_FE2      12'h105
`define SIDD_ADDR_FE3      12'h106
`define SIDD_ADDR_AUDCFG   12'h805
`define SIDD_ADDR_DMOVR    12'h8CD
`define SIDD_ADDR_GAIN     12'h8CE
`define SIDD_ADDR_STATE    12'h8CF
`define SIDD_REG_RESET     8'h00
`define SIDD_MISC_ADC2SEL  0
`define SIDD_FE1_OWNER     0
`define SIDD_FE2_AUDIN     0
`define SIDD_FE3_BOOST     0
`define SIDD_FE3_CLAMP     2
`define SIDD_CFG_STD_LO    0
`define SIDD_CFG_STD_HI    3
`define SIDD_CFG_MONO      4
`define SIDD_OVR_EN        0
`define SIDD_OVR_MODE_LO   1
`define SIDD_OVR_MODE_HI   2
`define SIDD_ANALOG_CH2    2'h2
`define SIDD_ANALOG_CH3    2'h3
`define SIDD_OUT_RATE_HZ   62937
`define SIDD_DEEMPH_75_US  75
`define SIDD_DEEMPH_50_US  50
`define SIDD_K_FRAC        8
`define SIDD_DEEMPH_K(t)   (256000000 / (`SIDD_OUT_RATE_HZ * (t)))
`define SIDD_AGC_SHIFT     6
`define SIDD_AGC_TARGET    384
`define SIDD_AGC_HYST      32
`define SIDD_AGC_RESET     6'h20
`define SIDD_GAIN_MAX      6'h3F
`define SIDD_GAIN_MIN      6'h00
`endif

// ### rtl/sidd_pkg.sv
// Types shared by the sound IF demodulator and dematrix
package sidd_pkg;
  typedef enum logic [3:0] {
    STD_BTSC = 4'h0, STD_EIAJ = 4'h1, STD_A2M = 4'h2, STD_A2BG = 4'h3,
    STD_A2DK = 4'h4, STD_NICAM = 4'h5, STD_FMI = 4'h6, STD_FMUS = 4'h7,
    STD_FMEU = 4'h8, STD_SAP = 4'h9, STD_AUTO = 4'hF
  } sidd_std_t;
  typedef enum logic [3:0] {
    CAR_4M5 = 4'h0, CAR_4M72 = 4'h1, CAR_5M5 = 4'h2, CAR_5M74 = 4'h3,
    CAR_5M85 = 4'h4, CAR_6M0 = 4'h5, CAR_6M26 = 4'h6, CAR_6M5 = 4'h7,
    CAR_6M552 = 4'h8, CAR_6M74 = 4'h9
  } sidd_carrier_t;
  typedef enum logic [1:0] {
    DMX_SUMDIFF = 2'h0, DMX_SUMR = 2'h1, DMX_LR = 2'h2, DMX_MONO = 2'h3
  } sidd_dmx_t;
  typedef enum logic [1:0] {
    DE_BYPASS = 2'h0, DE_75 = 2'h1, DE_50 = 2'h2
  } sidd_deemph_t;
endpackage

// ### rtl/sidd_dmx_if.sv
// Carrier between the demodulator core and the dematrix
interface sidd_dmx_if #(parameter int AUD_W = 16);
  logic signed [AUD_W-1:0] chA;
  logic signed [AUD_W-1:0] chB;
  sidd_pkg::sidd_dmx_t     mode;
  logic                    inValid;
  logic signed [AUD_W-1:0] outL;
  logic signed [AUD_W-1:0] outR;
  logic                    outValid;
  modport src (output chA, chB, mode, inValid, input outL, outR, outValid);
  modport dmx (input chA, chB, mode, inValid, output outL, outR, outValid);
endinterface

// ### rtl/sidd_agc.sv
// Audio AGC: running level average to a 6-bit front-end gain code
`include "sidd_defines.svh"
module sidd_agc #(
  parameter int SAMPLE_W = 10,
  parameter int PERIOD   = 64
) (
  input  wire logic                clk_sys,
  input  wire logic                rstSync_n,
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic                enable,
  output logic [5:0]               gainCode
);
  localparam int AVG_W = SAMPLE_W + `SIDD_AGC_SHIFT;
  localparam int CNT_W = $clog2(PERIOD);
  logic [AVG_W-1:0]    avg_reg;
  logic [CNT_W-1:0]    cnt_reg;
  logic [SAMPLE_W-1:0] mag;
  logic [SAMPLE_W-1:0] level;
  logic                tick;
  assign mag   = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;
  assign level = avg_reg[AVG_W-1 -: SAMPLE_W];
  assign tick  = sampleValid && enable && (cnt_reg == CNT_W'(PERIOD - 1));
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      avg_reg <= '0;
      cnt_reg <= '0;
    end else if (sampleValid && enable) begin
      avg_reg <= avg_reg + AVG_W'(mag) - AVG_W'(avg_reg >> `SIDD_AGC_SHIFT); // RULE_07
      cnt_reg <= tick ? '0 : cnt_reg + 1'b1;
    end
  end
  // Plain increment walks the linear step first, then carries into the log step
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      gainCode <= `SIDD_AGC_RESET;
    end else if (tick) begin // RULE_20
      if (level < SAMPLE_W'(`SIDD_AGC_TARGET - `SIDD_AGC_HYST) && gainCode != `SIDD_GAIN_MAX)
        gainCode <= gainCode + 6'h01; // RULE_08
      else if (level > SAMPLE_W'(`SIDD_AGC_TARGET + `SIDD_AGC_HYST) &&
               gainCode != `SIDD_GAIN_MIN)
        gainCode <= gainCode - 6'h01;
    end
  end
  agc_hold_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    !enable |=> $stable(gainCode)) else $error("gain moved while not owner"); // RULE_20
  agc_step_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    $changed(gainCode) |-> (gainCode == $past(gainCode) + 6'h01) ||
                           (gainCode == $past(gainCode) - 6'h01))
    else $error("gain jumped by more than one step"); // RULE_07
endmodule

// ### rtl/sidd_dematrix.sv
// Dematrix: stereo pair to discrete left and right
module sidd_dematrix #(
  parameter int AUD_W = 16
) (
  input  wire logic clk_sys,
  input  wire logic rstSync_n,
  sidd_dmx_if.dmx   dx
);
  logic signed [AUD_W:0] sum;
  logic signed [AUD_W:0] dif;
  function automatic logic signed [AUD_W-1:0] sat(input logic signed [AUD_W:0] v);
    if (v[AUD_W] != v[AUD_W-1])
      sat = v[AUD_W] ? {1'b1, {(AUD_W-1){1'b0}}} : {1'b0, {(AUD_W-1){1'b1}}};
    else
      sat = v[AUD_W-1:0];
  endfunction
  assign sum = (AUD_W+1)'(dx.chA) + (AUD_W+1)'(dx.chB);
  assign dif = (AUD_W+1)'(dx.chA) - (AUD_W+1)'(dx.chB);
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      dx.outL     <= '0;
      dx.outR     <= '0;
      dx.outValid <= 1'b0;
    end else begin
      dx.outValid <= dx.inValid;
      if (dx.inValid) begin
        unique case (dx.mode) // RULE_18
          sidd_pkg::DMX_SUMDIFF: begin
            dx.outL <= sat(sum); // RULE_13
            dx.outR <= sat(dif);
          end
          sidd_pkg::DMX_SUMR: begin
            dx.outL <= sat(dif); // RULE_14
            dx.outR <= dx.chB;
          end
          sidd_pkg::DMX_LR: begin
            dx.outL <= dx.chA; // RULE_15
            dx.outR <= dx.chB;
          end
          sidd_pkg::DMX_MONO: begin
            dx.outL <= dx.chA; // RULE_16
            dx.outR <= dx.chA;
          end
        endcase
      end
    end
  end
  dmx_lr_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    dx.inValid && dx.mode == sidd_pkg::DMX_LR |=>
      dx.outL == $past(dx.chA) && dx.outR == $past(dx.chB))
    else $error("direct mode altered samples"); // RULE_15
  dmx_mono_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    dx.inValid && dx.mode == sidd_pkg::DMX_MONO |=> dx.outL == dx.outR)
    else $error("mono outputs differ"); // RULE_16
endmodule

// ### rtl/sidd_top.sv
// Sound IF front-end control, audio AGC, demodulator paths, de-emphasis and dematrix
//
// Summary of operation
// RULE_01: Channel select bit routes CH2 or CH3
// RULE_02: Software clears impedance boost on IF channels
// RULE_03: Software clears clamp on IF channels
// RULE_04: Software sets audio input select high
// RULE_05: Owner bit gives channel gain to audio
// RULE_06: Three gains, two video, one audio
// RULE_07: AGC averages level into 6-bit gain
// RULE_08: Gain: two coarse log, four linear bits
// RULE_09: FM path for A2/BTSC/EIA-J, QPSK for NICAM
// RULE_10: Both paths output at decimated sample rate
// RULE_11: De-emphasis follows final filter, programmable
// RULE_12: 75us or 50us per standard; companding bypass
// RULE_13: Sum/difference for BTSC and EIA-J
// RULE_14: A2: left is difference, right passed (code does this for A2BG and A2DK only; A2M gets sum/difference)
// RULE_15: NICAM left and right pass unchanged
// RULE_16: Mono request drives both with sum
// RULE_17: Override bit selects programmed dematrix mode
// RULE_18: Mode codes: sum/diff, sum/R, LR, mono
// RULE_19: Core detects carrier standard, configures path
// RULE_20: Gain holds unless audio owns AGC
`include "sidd_defines.svh"
module sidd_top #(
  parameter int SAMPLE_W = 10,
  parameter int AUD_W    = 16,
  parameter int DECIM    = 455,
  parameter int AGC_PER  = 64
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   regWrEn,
  input  wire logic [11:0]            regAddr,
  input  wire logic [7:0]             regWrData,
  output logic [7:0]                  regRdData,
  input  wire logic                   sampleValid,
  input  wire logic [SAMPLE_W-1:0]    adcSample,
  input  wire logic                   carrierValid,
  input  wire logic [3:0]             carrierCode,
  input  wire logic [5:0]             videoGainA,
  input  wire logic [5:0]             videoGainB,
  output logic [1:0]                  adc2Channel,
  output logic [1:0]                  impedanceBoostEnable,
  output logic [1:0]                  inputClampEnable,
  output logic                        audioInputSelect,
  output logic [5:0]                  frontendGain [2],
  output logic [5:0]                  audioGain,
  output logic signed [AUD_W-1:0]     audioLeft,
  output logic signed [AUD_W-1:0]     audioRight,
  output logic                        audioValid
);
  localparam int ACC_MIN = SAMPLE_W + $clog2(DECIM) + 1;
  // Never narrower than the audio word, so a short window still fills the output slice
  localparam int ACC_W = (ACC_MIN > AUD_W) ? ACC_MIN : AUD_W;
  localparam int CNT_W = $clog2(DECIM);
  localparam int K_W   = `SIDD_K_FRAC + 1;
  localparam logic [K_W-1:0] K75 = K_W'(`SIDD_DEEMPH_K(`SIDD_DEEMPH_75_US));
  localparam logic [K_W-1:0] K50 = K_W'(`SIDD_DEEMPH_K(`SIDD_DEEMPH_50_US));

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rstPipe_reg;
  logic       rstSync_n;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      rstPipe_reg <= 2'b00;
    else
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
  end
  assign rstSync_n = rstPipe_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Host registers
  logic [7:0] misc_reg;
  logic [7:0] fe1_reg;
  logic [7:0] fe2_reg;
  logic [7:0] fe3_reg;
  logic [7:0] audCfg_reg;
  logic [7:0] dmOvr_reg;
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      misc_reg   <= `SIDD_REG_RESET;
      fe1_reg    <= `SIDD_REG_RESET;
      fe2_reg    <= `SIDD_REG_RESET;
      fe3_reg    <= `SIDD_REG_RESET;
      audCfg_reg <= `SIDD_REG_RESET;
      dmOvr_reg  <= `SIDD_REG_RESET;
    end else if (regWrEn) begin
      unique case (regAddr)
        `SIDD_ADDR_MISC:   misc_reg   <= regWrData;
        `SIDD_ADDR_FE1:    fe1_reg    <= regWrData;
        `SIDD_ADDR_FE2:    fe2_reg    <= regWrData;
        `SIDD_ADDR_FE3:    fe3_reg    <= regWrData;
        `SIDD_ADDR_AUDCFG: audCfg_reg <= regWrData;
        `SIDD_ADDR_DMOVR:  dmOvr_reg  <= regWrData;
        default: ;
      endcase
    end
  end

  sidd_pkg::sidd_std_t detStd_reg;
  sidd_pkg::sidd_std_t activeStd;
  sidd_pkg::sidd_dmx_t dmxMode;
  logic [7:0]          rdNext;
  always_comb begin
    unique case (regAddr)
      `SIDD_ADDR_MISC:   rdNext = misc_reg;
      `SIDD_ADDR_FE1:    rdNext = fe1_reg;
      `SIDD_ADDR_FE2:    rdNext = fe2_reg;
      `SIDD_ADDR_FE3:    rdNext = fe3_reg;
      `SIDD_ADDR_AUDCFG: rdNext = audCfg_reg;
      `SIDD_ADDR_DMOVR:  rdNext = dmOvr_reg;
      `SIDD_ADDR_GAIN:   rdNext = {2'b00, audioGain};
      `SIDD_ADDR_STATE:  rdNext = {2'b00, dmxMode, activeStd};
      default:           rdNext = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n)
      regRdData <= 8'h00;
    else
      regRdData <= rdNext;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog front-end control
  // Boost and clamp are passed as written; clearing them for IF use is software's job
  assign impedanceBoostEnable = fe3_reg[`SIDD_FE3_BOOST +: 2];
  assign inputClampEnable     = fe3_reg[`SIDD_FE3_CLAMP +: 2];
  assign audioInputSelect     = fe2_reg[`SIDD_FE2_AUDIN];
  assign adc2Channel = misc_reg[`SIDD_MISC_ADC2SEL] ? `SIDD_ANALOG_CH3 // RULE_01
                                                    : `SIDD_ANALOG_CH2;

  logic [5:0] videoGain [2];
  logic [1:0] ownerSel;
  logic       agcEnable;
  assign videoGain[0] = videoGainA;
  assign videoGain[1] = videoGainB;
  assign ownerSel     = fe1_reg[`SIDD_FE1_OWNER +: 2];
  // Only the channel feeding the second ADC closes the audio loop
  assign agcEnable = ownerSel[misc_reg[`SIDD_MISC_ADC2SEL]]; // RULE_20

  for (genvar c = 0; c < 2; c++) begin : g_gain
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n)
        frontendGain[c] <= `SIDD_AGC_RESET;
      else
        frontendGain[c] <= ownerSel[c] ? audioGain : videoGain[c]; // RULE_05 RULE_06
    end
  end

  sidd_agc #(
    .SAMPLE_W (SAMPLE_W),
    .PERIOD   (AGC_PER)
  ) u_agc (
    .clk_sys     (clk_sys),
    .rstSync_n   (rstSync_n),
    .sampleValid (sampleValid),
    .sample      (adcSample),
    .enable      (agcEnable),
    .gainCode    (audioGain)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Standard detection and path configuration
  sidd_pkg::sidd_std_t cfgStd;
  sidd_pkg::sidd_std_t carStd;
  assign cfgStd = sidd_pkg::sidd_std_t'(audCfg_reg[`SIDD_CFG_STD_HI:`SIDD_CFG_STD_LO]);
  always_comb begin
    unique case (sidd_pkg::sidd_carrier_t'(carrierCode))
      sidd_pkg::CAR_4M5:   carStd = sidd_pkg::STD_BTSC;
      sidd_pkg::CAR_4M72:  carStd = sidd_pkg::STD_A2M;
      sidd_pkg::CAR_5M5,
      sidd_pkg::CAR_5M74:  carStd = sidd_pkg::STD_A2BG;
      sidd_pkg::CAR_5M85,
      sidd_pkg::CAR_6M552: carStd = sidd_pkg::STD_NICAM;
      sidd_pkg::CAR_6M0:   carStd = sidd_pkg::STD_FMI;
      sidd_pkg::CAR_6M26,
      sidd_pkg::CAR_6M5,
      sidd_pkg::CAR_6M74:  carStd = sidd_pkg::STD_A2DK;
      default:             carStd = detStd_reg;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n)
      detStd_reg <= sidd_pkg::STD_BTSC;
    else if (carrierValid)
      detStd_reg <= carStd; // RULE_19
  end
  assign activeStd = (cfgStd == sidd_pkg::STD_AUTO) ? detStd_reg : cfgStd;

  logic                monoPref;
  sidd_pkg::sidd_dmx_t autoMode;
  assign monoPref = audCfg_reg[`SIDD_CFG_MONO];
  always_comb begin
    unique case (activeStd)
      sidd_pkg::STD_A2BG,
      sidd_pkg::STD_A2DK:  autoMode = sidd_pkg::DMX_SUMR;
      sidd_pkg::STD_NICAM,
      sidd_pkg::STD_SAP:   autoMode = sidd_pkg::DMX_LR;
      sidd_pkg::STD_FMI:   autoMode = sidd_pkg::DMX_MONO;
      default:             autoMode = sidd_pkg::DMX_SUMDIFF;
    endcase
    if (monoPref)
      autoMode = sidd_pkg::DMX_MONO;
  end
  assign dmxMode = dmOvr_reg[`SIDD_OVR_EN] // RULE_17
                 ? sidd_pkg::sidd_dmx_t'(dmOvr_reg[`SIDD_OVR_MODE_HI:`SIDD_OVR_MODE_LO])
                 : autoMode;

  sidd_pkg::sidd_deemph_t deMain;
  sidd_pkg::sidd_deemph_t deSub;
  always_comb begin
    unique case (activeStd) // RULE_12
      sidd_pkg::STD_FMI, sidd_pkg::STD_A2BG,
      sidd_pkg::STD_A2DK, sidd_pkg::STD_FMEU: deMain = sidd_pkg::DE_50;
      sidd_pkg::STD_NICAM:                    deMain = sidd_pkg::DE_BYPASS;
      default:                                deMain = sidd_pkg::DE_75;
    endcase
    unique case (activeStd)
      sidd_pkg::STD_BTSC, sidd_pkg::STD_SAP:  deSub = sidd_pkg::DE_BYPASS;
      default:                                deSub = deMain;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Demodulator paths: 0 = FM-type, 1 = QPSK
  logic                    route;
  logic [CNT_W-1:0]        decCnt_reg;
  logic                    dump;
  logic [SAMPLE_W-1:0]     prev_reg;
  logic signed [ACC_W-1:0] accA [2];
  logic signed [ACC_W-1:0] accB [2];
  logic signed [ACC_W-1:0] xA;
  logic signed [ACC_W-1:0] xB;
  assign route = (activeStd == sidd_pkg::STD_NICAM); // RULE_09
  assign dump  = sampleValid && (decCnt_reg == CNT_W'(DECIM - 1));
  assign xA    = ACC_W'(signed'(adcSample));
  assign xB    = ACC_W'(signed'(adcSample)) - ACC_W'(signed'(prev_reg));

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      decCnt_reg <= '0;
      prev_reg   <= '0;
    end else if (sampleValid) begin
      decCnt_reg <= dump ? '0 : decCnt_reg + 1'b1; // RULE_10
      prev_reg   <= adcSample;
    end
  end

  // Integrate-and-dump is the final filter of each path
  for (genvar p = 0; p < 2; p++) begin : g_path
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n) begin
        accA[p] <= '0;
        accB[p] <= '0;
      end else if (sampleValid && route == 1'(p)) begin
        accA[p] <= dump ? xA : accA[p] + xA;
        accB[p] <= dump ? xB : accB[p] + xB;
      end
    end
  end

  logic signed [AUD_W-1:0] filt [2];
  logic                    filtValid_reg;
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      filt[0]       <= '0;
      filt[1]       <= '0;
      filtValid_reg <= 1'b0;
    end else begin
      filtValid_reg <= dump;
      if (dump) begin
        filt[0] <= accA[route][ACC_W-1 -: AUD_W];
        filt[1] <= accB[route][ACC_W-1 -: AUD_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // De-emphasis: first-order low-pass, coefficient from the time constant
  sidd_pkg::sidd_deemph_t deSel [2];
  logic signed [AUD_W-1:0] deOut [2];
  logic                    deValid_reg;
  assign deSel[0] = deMain;
  assign deSel[1] = deSub;
  for (genvar c = 0; c < 2; c++) begin : g_deemph
    logic signed [AUD_W:0]         err;
    logic signed [AUD_W+K_W+1:0]   prod;
    logic [K_W-1:0]                k;
    assign k    = (deSel[c] == sidd_pkg::DE_50) ? K50 : K75;
    assign err  = (AUD_W+1)'(filt[c]) - (AUD_W+1)'(deOut[c]);
    assign prod = (AUD_W+K_W+2)'(err) * (AUD_W+K_W+2)'(signed'({1'b0, k}));
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n)
        deOut[c] <= '0;
      else if (filtValid_reg) begin
        if (deSel[c] == sidd_pkg::DE_BYPASS)
          deOut[c] <= filt[c]; // RULE_12
        else
          deOut[c] <= deOut[c] + AUD_W'(prod >>> `SIDD_K_FRAC); // RULE_11
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n)
      deValid_reg <= 1'b0;
    else
      deValid_reg <= filtValid_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dematrix and output
  sidd_dmx_if #(.AUD_W(AUD_W)) dmxBus ();
  assign dmxBus.chA     = deOut[0];
  assign dmxBus.chB     = deOut[1];
  assign dmxBus.mode    = dmxMode;
  assign dmxBus.inValid = deValid_reg;

  sidd_dematrix #(
    .AUD_W (AUD_W)
  ) u_dmx (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .dx        (dmxBus.dmx)
  );

  assign audioLeft  = dmxBus.outL;
  assign audioRight = dmxBus.outR;
  assign audioValid = dmxBus.outValid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_dump;
    sampleValid && decCnt_reg == CNT_W'(DECIM - 1);
  endsequence
  sequence s_outPulse;
    ##3 audioValid;
  endsequence

  adc2_route_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    adc2Channel == (misc_reg[`SIDD_MISC_ADC2SEL] ? 2'h3 : 2'h2))
    else $error("second ADC channel wrong"); // RULE_01
  gain_owner_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    ownerSel[0] |=> frontendGain[0] == $past(audioGain))
    else $error("audio owner not driving gain"); // RULE_05
  gain_video_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    rstSync_n && !ownerSel[1] |=> frontendGain[1] == $past(videoGainB))
    else $error("video gain not passed"); // RULE_06
  path_idle_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    route |=> $stable(accA[0]))
    else $error("FM path ran during NICAM"); // RULE_09
  out_rate_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    s_dump |-> s_outPulse)
    else $error("decimated sample not delivered"); // RULE_10
  ovr_mode_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    dmOvr_reg[`SIDD_OVR_EN] |-> dmxMode == dmOvr_reg[`SIDD_OVR_MODE_HI:`SIDD_OVR_MODE_LO])
    else $error("override mode ignored"); // RULE_17
  comp_bypass_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    filtValid_reg && deSub == sidd_pkg::DE_BYPASS |=> deOut[1] == $past(filt[1]))
    else $error("companded channel was filtered"); // RULE_12
  auto_std_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    carrierValid && carrierCode == 4'h4 |=> detStd_reg == sidd_pkg::STD_NICAM)
    else $error("NICAM carrier not detected"); // RULE_19
endmodule

// ### tb/sidd_tuner_model.sv
// Tuner sound IF source model: one sample strobe every fourth clock while run is high
module sidd_tuner_model (
  input  wire logic       clk_sys,
  input  wire logic       run,
  output logic            sampleValid,
  output logic [9:0]      adcSample
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase = 2'h0;
  logic [9:0] level = 10'h000;
  initial sampleValid = 1'b0;
  initial adcSample = 10'h000;
  always @(posedge clk_sys) begin
    phase <= phase + 2'h1;
    sampleValid <= run && (phase == 2'h3);
    if (run && (phase == 2'h3)) begin
      level <= level + 10'h025;
      adcSample <= level;
    end else begin
      // Between strobes the line is not held, so show the inverse of the last value
      adcSample <= ~adcSample;
    end
  end
endmodule

// ### tb/sound_if_demod_dematrix_tb.sv
// Self-checking bench for the sound IF control, front-end gain ownership and dematrix selection
module sound_if_demod_dematrix_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEC = 8;
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  logic              regWrEn = 1'b0;
  logic [11:0]       regAddr = 12'h000;
  logic [7:0]        regWrData = 8'h00;
  logic [7:0]        regRdData;
  logic              run = 1'b0;
  logic              sampleValid;
  logic [9:0]        adcSample;
  logic              carrierValid = 1'b0;
  logic [3:0]        carrierCode = 4'h0;
  logic [1:0]        adc2Channel, impedanceBoostEnable, inputClampEnable;
  logic              audioInputSelect, audioValid;
  logic [5:0]        frontendGain [2];
  logic [5:0]        audioGain;
  logic signed [15:0] audioLeft, audioRight;
  int                mismatches = 0;
  int                checks = 0;
  logic [7:0]        frames = 8'h00;
  logic signed [15:0] sumA = 16'h0000;
  logic signed [15:0] expA = 16'h0000;
  logic [7:0]        nSamp = 8'h00;
  // Rows: address, data, readback, adc2 channel, boost and clamp (one shared row), audio input select
  logic [11:0] rA [7] = '{12'h102, 12'h102, 12'h106, 12'h106, 12'h105, 12'h8CE, 12'h0FE};
  logic [7:0]  rD [7] = '{8'h01, 8'h00, 8'h0F, 8'h00, 8'h01, 8'hFF, 8'h55};
  logic [7:0]  rR [7] = '{8'h01, 8'h00, 8'h0F, 8'h00, 8'h01, 8'h20, 8'h00};
  logic [1:0]  rC [7] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
  logic [1:0]  rB [7] = '{2'h0, 2'h0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
  logic        rS [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  always #5 clk_sys = ~clk_sys;
  sidd_tuner_model tuner (.clk_sys(clk_sys), .run(run), .sampleValid(sampleValid),
    .adcSample(adcSample));
  sidd_top #(.DECIM(DEC), .AGC_PER(4)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .sampleValid(sampleValid), .adcSample(adcSample), .carrierValid(carrierValid),
    .carrierCode(carrierCode), .videoGainA(6'h11), .videoGainB(6'h2A),
    .adc2Channel(adc2Channel), .impedanceBoostEnable(impedanceBoostEnable),
    .inputClampEnable(inputClampEnable), .audioInputSelect(audioInputSelect),
    .frontendGain(frontendGain), .audioGain(audioGain), .audioLeft(audioLeft),
    .audioRight(audioRight), .audioValid(audioValid));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkAudio(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    repeat (2) @(posedge clk_sys);
    #1 chk("regRdData", exp, regRdData);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Mono selection puts channel A, the window sum, on both outputs;
  // the dump sample opens the next window
  always @(posedge clk_sys) begin
    if (sampleValid === 1'b1) begin
      nSamp <= (nSamp == 8'(DEC - 1)) ? 8'h00 : nSamp + 8'h01;
      sumA <= (nSamp == 8'(DEC - 1)) ? 16'(signed'(adcSample))
                                     : sumA + 16'(signed'(adcSample));
      if (nSamp == 8'(DEC - 1))
        expA <= sumA;
    end
    if (audioValid === 1'b1) begin
      frames <= frames + 8'h01;
      chkAudio("audioLeft", expA, audioLeft);
      chkAudio("audioRight", expA, audioRight);
    end
  end
  initial begin
    #100000 mismatches++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("adc2Channel", 8'h02, {6'h00, adc2Channel});
    chk("audioGain", 8'h20, {2'h0, audioGain});
    for (int i = 0; i < 7; i++) begin
      wr(rA[i], rD[i]);
      rdchk(rA[i], rR[i]);
      chk("adc2Channel", {6'h00, rC[i]}, {6'h00, adc2Channel});
      chk("boost", {6'h00, rB[i]}, {6'h00, impedanceBoostEnable});
      chk("clamp", {6'h00, rB[i]}, {6'h00, inputClampEnable});
      chk("audioIn", {7'h00, rS[i]}, {7'h00, audioInputSelect});
    end
    chk("gainA", 8'h11, {2'h0, frontendGain[0]});
    chk("gainB", 8'h2A, {2'h0, frontendGain[1]});
    wr(12'h104, 8'h03);
    rdchk(12'h104, 8'h03);
    // No samples yet, so the audio code still holds its reset value
    chk("gainA", 8'h20, {2'h0, frontendGain[0]});
    chk("gainB", 8'h20, {2'h0, frontendGain[1]});
    wr(12'h805, 8'h0F);
    @(posedge clk_sys);
    carrierValid <= 1'b1;
    carrierCode <= 4'h4;
    @(posedge clk_sys);
    carrierValid <= 1'b0;
    rdchk(12'h8CF, 8'h25);
    for (int m = 0; m < 4; m++) begin
      wr(12'h8CD, {5'h00, m[1:0], 1'b1});
      rdchk(12'h8CF, {2'h0, m[1:0], 4'h5});
    end
    @(posedge clk_sys);
    run <= 1'b1;
    repeat (4 * 3 * DEC) @(posedge clk_sys);
    run <= 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 chk("frames", 8'h03, frames);
    // Reset after the run has stopped must bring back the dematrix override register and the video gain path
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1 chk("gainA", 8'h20, {2'h0, frontendGain[0]});
    repeat (3) @(posedge clk_sys);
    rdchk(12'h8CD, 8'h00);
    chk("gainA", 8'h11, {2'h0, frontendGain[0]});
    wrap_up();
  end
endmodule
